// [afe_pkg.sv]
package afe_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 20;
    localparam int SCLK_HALF_NS      = 40;
    localparam int SCLK_HALF_CYC     = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_TIME_US      = 375;
    localparam int WAKE_CYC          = (WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TUNE_ADC_CYC      = 512;
    localparam int ADC_CLK_PERIOD_NS = 25;
    localparam int TUNE_CYC          = (TUNE_ADC_CYC * ADC_CLK_PERIOD_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int DIV_W             = 4;
    localparam int WAIT_W            = 24;

    // ------------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------------
    localparam int         FRAME_BITS   = 24;
    localparam int         BIT_CNT_W    = 5;
    localparam logic       OP_WRITE     = 1'b0;
    localparam logic [1:0] LEN_ONE_BYTE = 2'b00;
    localparam logic       ADDR_TOP_PAD = 1'b0;

    // ------------------------------------------------------------------
    // Own register map (APB, byte addresses)
    // ------------------------------------------------------------------
    localparam int          APB_ADDR_W       = 12;
    localparam logic [11:0] CTRL_OFS         = 12'h000;
    localparam logic [11:0] STATUS_OFS       = 12'h004;
    localparam int          CTRL_START_BIT   = 0;
    localparam int          CTRL_GRADE_LSB   = 1;
    localparam int          CTRL_TRIG_BIT    = 3;
    localparam int          STAT_BUSY_BIT    = 0;
    localparam int          STAT_DONE_BIT    = 1;
    localparam int          STAT_WAIT_BIT    = 2;
    localparam int          STAT_SDIO_BIT    = 3;
    localparam int          STAT_STEP_LSB    = 8;
    localparam logic [1:0]  GRADE_RESET      = 2'h0;
    localparam logic        TRIG_EN_RESET    = 1'b1;
    localparam int          GRADE_FIELD_LSB  = 4;

    // ------------------------------------------------------------------
    // Start-up sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AFE_WAIT_NONE = 2'b00,
        AFE_WAIT_WAKE = 2'b01,
        AFE_WAIT_TUNE = 2'b10
    } afe_wait_t;

    typedef struct packed {
        afe_wait_t   waitSel;
        logic [11:0] addr;
        logic [7:0]  data;
    } afe_step_t;

    typedef struct packed {
        logic sclk;
        logic chipSelectLowN;
        logic sdioOut;
        logic sdioOe;
    } afe_pins_t;

    localparam int         NUM_STEPS  = 28;
    localparam int         STEP_W     = 5;
    localparam logic [4:0] GRADE_STEP = 5'h01;
    localparam logic [4:0] TRIG_STEP  = 5'h19;

    localparam afe_step_t SEQ [NUM_STEPS] = '{
        '{AFE_WAIT_NONE, 12'h000, 8'h3C}, '{AFE_WAIT_NONE, 12'h002, 8'h00},
        '{AFE_WAIT_NONE, 12'h0FF, 8'h01}, '{AFE_WAIT_NONE, 12'h004, 8'h0F},
        '{AFE_WAIT_NONE, 12'h005, 8'h3F}, '{AFE_WAIT_NONE, 12'h113, 8'h00},
        '{AFE_WAIT_NONE, 12'h011, 8'h06}, '{AFE_WAIT_NONE, 12'hF00, 8'hFF},
        '{AFE_WAIT_NONE, 12'hF01, 8'h7F}, '{AFE_WAIT_NONE, 12'hF02, 8'h00},
        '{AFE_WAIT_NONE, 12'hF03, 8'h80}, '{AFE_WAIT_NONE, 12'h10C, 8'h00},
        '{AFE_WAIT_NONE, 12'h10C, 8'h00}, '{AFE_WAIT_NONE, 12'h014, 8'h00},
        '{AFE_WAIT_WAKE, 12'h008, 8'h00}, '{AFE_WAIT_NONE, 12'h021, 8'h12},
        '{AFE_WAIT_NONE, 12'h199, 8'h80}, '{AFE_WAIT_NONE, 12'h142, 8'h04},
        '{AFE_WAIT_NONE, 12'h188, 8'h01}, '{AFE_WAIT_NONE, 12'h18B, 8'h27},
        '{AFE_WAIT_NONE, 12'h18C, 8'h72}, '{AFE_WAIT_NONE, 12'h150, 8'h03},
        '{AFE_WAIT_NONE, 12'h182, 8'h82}, '{AFE_WAIT_NONE, 12'h181, 8'h02},
        '{AFE_WAIT_NONE, 12'h186, 8'hAA}, '{AFE_WAIT_NONE, 12'h10C, 8'h20},
        '{AFE_WAIT_NONE, 12'h00F, 8'h18}, '{AFE_WAIT_TUNE, 12'h02B, 8'h40}
    };

endpackage : afe_pkg

// [afe_startup_host.sv]
// Added by the designer: the APB slave port.
`timescale 1ns/1ps

//Function
// R01: Device starts fully powered down; nothing converts until software runs it.
// R02: Profile zero entries at 0xF00..0xF07 are written before the chip runs; the table writes only 0xF00..0xF03.
// R03: Any further profiles or coefficients follow profile zero, never before.
// R04: Port reset 0x3C to 0x000, speed grade at 0x002, commit 0x01 at 0x0FF.
// R05: Channel select all: 0x0F to 0x004 and 0x3F to 0x005.
// R06: Write 0x00 to 0x113: decimator bypassed, high-pass kept on.
// R07: Write 0x06 to 0x011 for preamp gain, gain pins, post gain.
// R08: Continuous run: 0xFF to 0xF00 and 0x7F to 0xF01.
// R09: Write 0x00 to 0xF02: channels wake zero cycles after transmit trigger.
// R10: Write 0x80 to 0xF03: digital high-pass bypassed for the profile.
// R11: After profile memory, write profile index 0x00.
// R12: One further MSB-first write completes the profile buffer before run.
// R13: Write 0x00 to 0x014 for output format before running.
// R14: Write 0x00 to 0x008 to run; then wait 375 us for wake.
// R15: Link mode 0x12 to 0x021; scrambler off, four lanes 0x03 to 0x150.
// R16: Write 0x80 to 0x199 enabling the serializer sample clock counter.
// R17: Start code enable 0x01 at 0x188, then 0x27 high, 0x72 low.
// R18: Write 0xAA to 0x186 so continuous resync stays off.
// R19: Soft transmit trigger 0x20 runs decimator and filter; optional.
// R20: Write 0x18 to 0x00F for low-pass cutoff before tuning.
// R21: Write 0x40 to 0x02B starts tuning; wait 512 ADC clocks.
// R22: Frame opens with chip select low, 16-bit instruction, then data bytes.
// R23: Writes go strictly in order, one frame at a time, with waits.
module afe_startup_host
    import afe_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output      logic [31:0]           prdata,
    output      logic                  pready,
    output      logic                  pslverr,
    // Serial port pins
    output      afe_pins_t             spiPins,
    input  wire logic                  sdioIn
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_GAP   = 3'b011,
        ST_WAIT  = 3'b100,
        ST_DONE  = 3'b101
    } afe_state_t;

    localparam logic [DIV_W-1:0]     DIV_LAST  = DIV_W'(SCLK_HALF_CYC - 1);
    localparam logic [BIT_CNT_W-1:0] BIT_LAST  = BIT_CNT_W'(FRAME_BITS - 1);
    localparam logic [STEP_W-1:0]    STEP_LAST = STEP_W'(NUM_STEPS - 1);
    localparam logic [WAIT_W-1:0]    WAKE_LOAD = WAIT_W'(WAKE_CYCLES - 1);
    localparam logic [WAIT_W-1:0]    TUNE_LOAD = WAIT_W'(TUNE_CYC - 1);

    afe_state_t                 state_q;
    afe_pins_t                  pins_q;
    logic [DIV_W-1:0]           divCnt_q;
    logic                       tick;
    logic [FRAME_BITS-1:0]      shift_q;
    logic [BIT_CNT_W-1:0]       bitCnt_q;
    logic                       shiftPend_q;
    logic [STEP_W-1:0]          stepIdx_q;
    logic [STEP_W-1:0]          nextIdx;
    logic [WAIT_W-1:0]          waitCnt_q;
    logic                       done_q;
    logic                       startReq_q;
    logic [1:0]                 grade_q;
    logic                       trigEn_q;
    logic                       apbAccess;
    logic                       sdioS1_q;
    logic                       sdioS2_q;
    logic                       sdioS3_q;
    logic                       sdioSeen_q;
    afe_step_t                  curStep;
    logic [7:0]                 curData;

    assign spiPins = pins_q;
    assign curStep = SEQ[stepIdx_q];                  // R02 R03 R05 R06 R07 R08 R09 R10

    // ------------------------------------------------------------------
    // APB slave: own control and status registers
    // ------------------------------------------------------------------

    // One wait state per access, answer registered
    assign apbAccess = psel && penable && !pready;

    always_ff @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apbAccess;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (apbAccess) begin
                if (paddr == STATUS_OFS && !pwrite) begin
                    prdata[STAT_BUSY_BIT] <= (state_q != ST_IDLE);
                    prdata[STAT_DONE_BIT] <= done_q;
                    prdata[STAT_WAIT_BIT] <= (state_q == ST_WAIT);
                    prdata[STAT_SDIO_BIT] <= sdioSeen_q;
                    prdata[STAT_STEP_LSB +: STEP_W] <= stepIdx_q;
                end else if (paddr == CTRL_OFS) begin
                    prdata[CTRL_GRADE_LSB +: 2] <= grade_q;
                    prdata[CTRL_TRIG_BIT]       <= trigEn_q;
                end else if (paddr != STATUS_OFS) begin
                    pslverr <= 1'b1;                     // Unmapped
                end
            end
        end
    end

    // Control register and start pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            grade_q    <= GRADE_RESET;
            trigEn_q   <= TRIG_EN_RESET;
            startReq_q <= 1'b0;
        end else begin
            startReq_q <= 1'b0;
            if (apbAccess && pwrite && paddr == CTRL_OFS) begin
                grade_q    <= pwdata[CTRL_GRADE_LSB +: 2];
                trigEn_q   <= pwdata[CTRL_TRIG_BIT];     // R19
                startReq_q <= pwdata[CTRL_START_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Data pin input synchroniser
    // ------------------------------------------------------------------

    // Three stages; level taken once the last two agree
    always_ff @(posedge clk) begin
        if (reset) begin
            sdioS1_q   <= 1'b0;
            sdioS2_q   <= 1'b0;
            sdioS3_q   <= 1'b0;
            sdioSeen_q <= 1'b0;
        end else begin
            sdioS1_q <= sdioIn;
            sdioS2_q <= sdioS1_q;
            sdioS3_q <= sdioS2_q;
            if (sdioS2_q == sdioS3_q) begin
                sdioSeen_q <= sdioS3_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial clock divider
    // ------------------------------------------------------------------

    // Half-period enable, restarted with each frame
    always_ff @(posedge clk) begin
        if (reset || state_q == ST_LOAD || state_q == ST_IDLE) begin
            divCnt_q <= '0;
        end else if (divCnt_q == DIV_LAST) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_q + 1'b1;
        end
    end

    assign tick = (divCnt_q == DIV_LAST);

    // ------------------------------------------------------------------
    // Step selection
    // ------------------------------------------------------------------

    // Next step, skipping the soft trigger when disabled
    always_comb begin
        nextIdx = stepIdx_q + 1'b1;
        if (nextIdx == TRIG_STEP && !trigEn_q) begin
            nextIdx = nextIdx + 1'b1;                    // R19
        end
    end

    // Speed grade taken from the control register
    always_comb begin
        curData = curStep.data;
        if (stepIdx_q == GRADE_STEP) begin
            curData = 8'h00;
            curData[GRADE_FIELD_LSB +: 2] = grade_q;     // R04
        end
    end

    // ------------------------------------------------------------------
    // Sequencer and frame engine
    // ------------------------------------------------------------------

    // Walks the table strictly in order, one frame at a time
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q     <= ST_IDLE;
            pins_q      <= '{sclk: 1'b0, chipSelectLowN: 1'b1, sdioOut: 1'b0, sdioOe: 1'b0};
            shift_q     <= '0;
            bitCnt_q    <= '0;
            shiftPend_q <= 1'b0;
            stepIdx_q   <= '0;
            waitCnt_q   <= '0;
            done_q      <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (startReq_q) begin
                        stepIdx_q <= '0;                 // R04 R23
                        done_q    <= 1'b0;
                        state_q   <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // Instruction then one data byte, MSB first
                    shift_q <= {OP_WRITE, LEN_ONE_BYTE, ADDR_TOP_PAD,
                                curStep.addr, curData};  // R22 R12 R11 R13
                    pins_q.chipSelectLowN <= 1'b0;       // R22
                    pins_q.sdioOe         <= 1'b1;
                    pins_q.sdioOut        <= OP_WRITE;
                    pins_q.sclk           <= 1'b0;
                    bitCnt_q              <= '0;
                    shiftPend_q           <= 1'b0;
                    state_q               <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (shiftPend_q) begin
                        // Data moves one cycle after the falling edge
                        shiftPend_q    <= 1'b0;
                        shift_q        <= {shift_q[FRAME_BITS-2:0], 1'b0};
                        pins_q.sdioOut <= shift_q[FRAME_BITS-2];
                    end
                    if (tick) begin
                        if (!pins_q.sclk) begin
                            pins_q.sclk <= 1'b1;
                        end else if (bitCnt_q == BIT_LAST) begin
                            pins_q.sclk <= 1'b0;
                            state_q     <= ST_GAP;
                        end else begin
                            pins_q.sclk <= 1'b0;
                            bitCnt_q    <= bitCnt_q + 1'b1;
                            shiftPend_q <= 1'b1;
                        end
                    end
                end
                ST_GAP: begin
                    // Close frame, hold select high a half period
                    pins_q.chipSelectLowN <= 1'b1;       // R23
                    pins_q.sdioOe         <= 1'b0;
                    pins_q.sdioOut        <= 1'b0;
                    if (tick) begin
                        if (curStep.waitSel == AFE_WAIT_WAKE) begin
                            waitCnt_q <= WAKE_LOAD;      // R14
                            state_q   <= ST_WAIT;
                        end else if (curStep.waitSel == AFE_WAIT_TUNE) begin
                            waitCnt_q <= TUNE_LOAD;      // R21
                            state_q   <= ST_WAIT;
                        end else if (stepIdx_q == STEP_LAST) begin
                            state_q <= ST_DONE;
                        end else begin
                            stepIdx_q <= nextIdx;        // R23 R15 R16 R17 R18 R20
                            state_q   <= ST_LOAD;
                        end
                    end
                end
                ST_WAIT: begin
                    if (waitCnt_q == '0) begin
                        if (stepIdx_q == STEP_LAST) begin
                            state_q <= ST_DONE;
                        end else begin
                            stepIdx_q <= nextIdx;        // R14
                            state_q   <= ST_LOAD;
                        end
                    end else begin
                        waitCnt_q <= waitCnt_q - 1'b1;
                    end
                end
                ST_DONE: begin
                    done_q  <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : afe_startup_host

// [afe_startup_host_asserts.sv]
`timescale 1ns/1ps
module afe_startup_host_asserts
    import afe_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  reset,
    // APB slave side
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Serial pins
    input wire afe_pins_t             spiPins,
    input wire logic                  sdioIn
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ------------
    // Sequences
    // ------------
    // Serial clock high two cycles, then low
    sequence s_sclkPulse;
        spiPins.sclk [*2] ##1 !spiPins.sclk;
    endsequence
    // Write bit first, two low cycles before first rise
    sequence s_frameOpen;
        !spiPins.sclk && !spiPins.sdioOut ##1 !spiPins.sclk ##1 spiPins.sclk;
    endsequence

    // ------------
    // Properties
    // ------------
    property p_rdyWait;
        psel && penable && !pready |=> pready;
    endproperty
    property p_rdyPulse;
        pready |=> !pready;
    endproperty
    property p_rdyCause;
        pready |-> $past(psel && penable);
    endproperty
    property p_errRdy;
        pslverr |-> pready;
    endproperty
    property p_rdataIdle;
        !pready |-> prdata == 32'h0;
    endproperty
    property p_oeFrame;
        spiPins.sdioOe == !spiPins.chipSelectLowN;
    endproperty
    property p_sclkIdle;
        spiPins.chipSelectLowN |-> !spiPins.sclk;
    endproperty
    property p_sclkHalf;
        $rose(spiPins.sclk) |-> s_sclkPulse;
    endproperty
    property p_dataHold;
        $rose(spiPins.sclk) |-> $stable(spiPins.sdioOut);
    endproperty
    property p_open;
        $fell(spiPins.chipSelectLowN) |-> s_frameOpen;
    endproperty
    property p_gap;
        $rose(spiPins.chipSelectLowN) |-> spiPins.chipSelectLowN [*2];
    endproperty

    // ------------
    // Assertions
    // ------------
    a_rdyWait: assert property (p_rdyWait)
        else $error("pready not one cycle after access");
    a_rdyPulse: assert property (p_rdyPulse)
        else $error("pready longer than one cycle");
    a_rdyCause: assert property (p_rdyCause)
        else $error("pready without access");
    a_errRdy: assert property (p_errRdy)
        else $error("pslverr without pready");
    a_rdataIdle: assert property (p_rdataIdle)
        else $error("prdata not zero outside answer");
    a_oeFrame: assert property (p_oeFrame)
        else $error("data enable differs from frame");
    a_sclkIdle: assert property (p_sclkIdle)
        else $error("serial clock moves outside frame");
    a_sclkHalf: assert property (p_sclkHalf)
        else $error("serial clock high time wrong");
    a_dataHold: assert property (p_dataHold)
        else $error("data changed at serial clock rise");
    a_open: assert property (p_open)
        else $error("frame opening wrong");
    a_gap: assert property (p_gap)
        else $error("chip select gap too short");
endmodule : afe_startup_host_asserts

// [afe_dev_model.sv]
`timescale 1ns/1ps
module afe_dev_model (
    // Serial pins from host
    input  wire logic sclk,
    input  wire logic chipSelectLowN,
    input  wire logic sdioOe,
    input  wire logic sdioOut,
    // Data pin level seen by host
    output      logic sdioIn
);
    logic [7:0]  regs [0:4095];
    logic [23:0] shiftQ;
    logic        lastBit;
    logic        powered;
    logic        filterRun;
    int          bitCnt;
    int          badFrames;
    logic [19:0] frameLog [$];
    realtime     endLog [$];

    // Released pin shows inverse of last driven bit
    assign sdioIn = sdioOe ? sdioOut : ~lastBit;
    always @* begin
        if (sdioOe)
            lastBit = sdioOut;
    end

    // Power-up and port-reset defaults
    task automatic load_defaults();
        foreach (regs[i])
            regs[i] = 8'h00;
        regs[12'h011] = 8'h06;
        powered = 1'b0;
        filterRun = 1'b0;
    endtask : load_defaults

    // Register write with side effects
    task automatic apply(input logic [11:0] a, input logic [7:0] d);
        frameLog.push_back({a, d});
        endLog.push_back($realtime);
        regs[a] = d;
        if (a == 12'h000 && (d & 8'h24) != 8'h00)
            load_defaults();
        if (a == 12'h008 && d == 8'h00)
            powered = 1'b1;
        if (a == 12'h10C && d[5])
            filterRun = 1'b1;
    endtask : apply

    initial begin
        lastBit = 1'b0;
        bitCnt = 0;
        badFrames = 0;
        load_defaults();
    end

    // Bits taken on serial clock rise inside frame
    always @(posedge sclk) begin
        if (!chipSelectLowN) begin
            shiftQ = {shiftQ[22:0], sdioIn};
            bitCnt++;
        end
    end

    // Frame closes: 24 bits, write, one byte
    always @(posedge chipSelectLowN) begin
        if (bitCnt != 0) begin
            if (bitCnt != 24 || shiftQ[23:20] != 4'h0)
                badFrames++;
            else
                apply(shiftQ[19:8], shiftQ[7:0]);
        end
        bitCnt = 0;
    end
endmodule : afe_dev_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import afe_pkg::*;
    localparam int WAKE_SIM = 400;
    logic                  clk;
    logic                  reset;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  sdioIn;
    afe_pins_t             spiPins;
    logic [31:0]           rdData;
    logic                  slvErr;
    int                    errCount;
    int                    totalChecks;
    logic [19:0]           expTab [28] = '{
        20'h0003C, 20'h00200, 20'h0FF01, 20'h0040F, 20'h0053F, 20'h11300, 20'h01106,
        20'hF00FF, 20'hF017F, 20'hF0200, 20'hF0380, 20'h10C00, 20'h10C00, 20'h01400,
        20'h00800, 20'h02112, 20'h19980, 20'h14204, 20'h18801, 20'h18B27, 20'h18C72,
        20'h15003, 20'h18282, 20'h18102, 20'h186AA, 20'h10C20, 20'h00F18, 20'h02B40};

    afe_startup_host #(.WAKE_CYCLES(WAKE_SIM)) u_afe_startup_host (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spiPins(spiPins), .sdioIn(sdioIn));
    afe_dev_model u_afe_dev_model (
        .sclk(spiPins.sclk), .chipSelectLowN(spiPins.chipSelectLowN),
        .sdioOe(spiPins.sdioOe), .sdioOut(spiPins.sdioOut), .sdioIn(sdioIn));

    // Clock
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // ------------
    // Tasks
    // ------------
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdData = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        check("apb answer", 32'(n < 50), 32'h1);
    endtask : apb

    // Reset values, read-only status, unmapped place
    task automatic test_regs();
        check("idle frames", 32'(u_afe_dev_model.frameLog.size()), 32'h0);
        check("idle power", 32'(u_afe_dev_model.powered), 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        check("ctrl reset", rdData, 32'h8);
        check("ctrl err", 32'(slvErr), 32'h0);
        apb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
        apb(1'b0, STATUS_OFS, 32'h0);
        check("status reset", rdData, 32'h8);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped err", 32'(slvErr), 32'h1);
        check("unmapped data", rdData, 32'h0);
    endtask : test_regs

    // Whole start-up run, with a refused second start
    task automatic run_seq(input logic [1:0] grade, input logic trig);
        int n;
        int k;
        realtime doneT;
        logic [19:0] exp;
        u_afe_dev_model.frameLog.delete();
        u_afe_dev_model.endLog.delete();
        apb(1'b1, CTRL_OFS, {28'h0, trig, grade, 1'b1});
        apb(1'b0, STATUS_OFS, 32'h0);
        check("busy", rdData & 32'h3, 32'h1);
        apb(1'b1, CTRL_OFS, {28'h0, trig, grade, 1'b1});
        n = 0;
        do begin
            apb(1'b0, STATUS_OFS, 32'h0);
            n++;
        end while (rdData[STAT_DONE_BIT] !== 1'b1 && n < 4000);
        doneT = $realtime;
        check("status done", rdData & 32'hF, 32'hA);
        check("frames", 32'(u_afe_dev_model.frameLog.size()), trig ? 32'h1C : 32'h1B);
        k = 0;
        for (int i = 0; i < 28; i++) begin
            if (i == 25 && !trig)
                continue;
            exp = expTab[i];
            if (i == 1)
                exp[7:0] = {2'h0, grade, 4'h0};
            check("frame", 32'(u_afe_dev_model.frameLog[k]), 32'(exp));
            k++;
        end
        check("wake gap", 32'(u_afe_dev_model.endLog[15] - u_afe_dev_model.endLog[14]
            >= (WAKE_SIM + 96) * CLK_PERIOD_NS), 32'h1);
        check("tune gap", 32'(doneT - u_afe_dev_model.endLog[k-1]
            >= TUNE_CYC * CLK_PERIOD_NS), 32'h1);
        check("powered", 32'(u_afe_dev_model.powered), 32'h1);
        check("filter run", 32'(u_afe_dev_model.filterRun), 32'(trig));
        check("bad frames", 32'(u_afe_dev_model.badFrames), 32'h0);
    endtask : run_seq

    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : reportAndStop

    // ------------
    // Main sequence
    // ------------
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        errCount = 0;
        totalChecks = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        test_regs();
        run_seq(2'h2, 1'b1);
        run_seq(2'h1, 1'b0);
        reportAndStop();
    end

    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk);
        errCount++;
        reportAndStop();
    end
endmodule : tb_top

bind afe_startup_host afe_startup_host_asserts u_afe_startup_host_asserts (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spiPins(spiPins), .sdioIn(sdioIn));
